// ---- vic_cfg.svh ----
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// Program counter width (4K program space)
`define VIC_PC_W 12
// Register byte offsets
`define VIC_OFF_CTLA 5'h00
`define VIC_OFF_CTLB 5'h04
`define VIC_OFF_MFIC 5'h08
`define VIC_OFF_MISC 5'h0C
`define VIC_OFF_ROUT 5'h10
`define VIC_OFF_STAT 5'h14
// Read masks: unimplemented bits read as zero
`define VIC_MASK_CTLA 8'h7F
`define VIC_MASK_CTLB 8'h66
`define VIC_MASK_MFIC 8'h77
`define VIC_MASK_MISC 8'hC0
`define VIC_MASK_ROUT 8'hEB
`define VIC_RST_REG 8'h00
// Vector addresses in priority order
`define VIC_VEC_EXT 8'h04
`define VIC_VEC_T0 8'h08
`define VIC_VEC_T1 8'h0C
`define VIC_VEC_TB 8'h14
`define VIC_VEC_MF 8'h18
// Edge select codes
`define VIC_EXT_OFF 2'b00
`define VIC_EXT_RISE 2'b01
`define VIC_EXT_FALL 2'b10
`define VIC_EXT_BOTH 2'b11
`define VIC_CMP_FALL 2'b00
`define VIC_CMP_RISE 2'b01
`define VIC_CMP_BOTH 2'b10
// Input select code meaning internal reference
`define VIC_SEL_INTREF 3'b000
// Vector latency in instruction cycles
`define VIC_LAT_RUN 2'd2
`define VIC_LAT_WAKE 2'd3
`endif

// ---- vic_pkg.sv ----
`include "vic_cfg.svh"
package vic_pkg;
    typedef struct packed {
        logic timer0_ovf;
        logic timer1_ovf;
        logic time_base;
        logic ext_pin;
        logic cmp_out;
        logic amp0_out;
        logic amp1_out;
    } vic_src_t;
    typedef struct packed {
        logic push;
        logic load;
        logic pop;
        logic [`VIC_PC_W-1:0] addr;
    } vic_cpu_t;
    typedef enum logic [3:0] {
        VIC_IDLE = 4'b0001,
        VIC_WAIT = 4'b0010,
        VIC_PUSH = 4'b0100,
        VIC_JUMP = 4'b1000
    } vic_state_t;
endpackage

// ---- vic_ctrl.sv ----
`timescale 1ns/1ps
`include "vic_cfg.svh"
// Notes on behaviour
// - Comparator irq edge: 00 falling, 01 rising, 10 both, 11 reserved.
// - Timer 0 event source: 0 external timer pin, 1 comparator output.
// - Ref join bits add external pin only while internal reference selected.
// - Routing register bits 4 and 2 read as zero.
// - Global enable clear means no vectoring at all.
// - Each source event sets its own request flag.
// - On accept push next address, then load vector into PC.
// - Return from irq pops saved PC and resumes.
// - Servicing clears the global enable automatically.
// - Requests during servicing still set and hold their flags.
// - No acknowledge while return stack is full.
// - Vector jump after 2 or 3 instruction cycles, 3 on wake.
// - Requests sampled and serviced at next second-phase pulse.
// - Priority: external 04H, timer 0 08H, timer 1 0CH.
// - Time base fourth 14H, multi-source fifth 18H.
// - External irq needs global enable, ext enable and its flag.
// - Ext edge bits 7:6: 00 off, 01 rise, 10 fall, 11 both.
// - Servicing external irq clears its request flag.
// - Pull-up on the shared pin stays in effect.
// - Multi-source flag set by amp fall or comparator edge; sub-flags record.
// - Set flags stay until serviced or cleared by software.
// - Bit 0 of control register A is global enable.
module vic_ctrl (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input vic_pkg::vic_src_t src_in,
    input wire logic timer0_ext_input_pin_in,
    input wire logic [2:0] amp0_noninv_sel_in,
    input wire logic [2:0] amp1_noninv_sel_in,
    input wire logic [2:0] cmp_noninv_sel_in,
    input wire logic ext_pullup_en_in,
    input wire logic second_clock_phase_in,
    input wire logic sleep_wake_in,
    input wire logic stack_full_in,
    input wire logic return_from_irq_instr_in,
    input wire logic [`VIC_PC_W-1:0] pc_next_in,
    output logic irq_pending_out,
    output logic [7:0] irq_vector_out,
    output vic_pkg::vic_cpu_t cpu_ctl_out,
    output logic timer0_event_out,
    output logic amp0_ref_pin_join_out,
    output logic amp1_ref_pin_join_out,
    output logic cmp_ref_pin_join_out,
    output logic ext_pin_pullup_out
);
    import vic_pkg::*;

    // Software-owned bits; flags live in req_r and sub_r
    logic [3:0] ctla_r;
    logic [2:0] ctlb_r;
    logic [2:0] mfic_r;
    logic [7:0] misc_r;
    logic [7:0] rout_r;
    // Request flags: 0 ext, 1 t0, 2 t1, 3 tb, 4 multi-source
    logic [4:0] req_r;
    logic [2:0] sub_r;
    logic [4:0] en;
    logic [4:0] live;
    logic [4:0] win;
    logic [4:0] svc;
    logic [4:0] ev;
    logic [4:0] req_wr;
    logic [4:0] req_wd;
    logic [2:0] sub_ev;
    logic [2:0] sub_wd;
    logic [7:0] win_vec;
    logic gie;
    logic capture;
    logic ack_r;
    logic [31:0] rdata_nxt;
    logic wr_go;
    logic wr_a;
    logic wr_b;
    logic wr_m;
    // Edge history of level sources
    logic ext_q_r;
    logic cmp_q_r;
    logic amp0_q_r;
    logic amp1_q_r;
    logic ext_rise;
    logic ext_fall;
    logic cmp_rise;
    logic cmp_fall;
    logic ext_evt;
    logic cmp_evt;
    // Sequencer
    vic_state_t state_r;
    vic_state_t state_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [7:0] vec_r;

    assign gie = ctla_r[0];
    assign en = {ctlb_r[2], ctlb_r[1], ctla_r[3], ctla_r[2], ctla_r[1]};

    // Edge detection on level sources; history resets low so a high level at reset looks like a rise
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_q_r <= 1'b0;
            cmp_q_r <= 1'b0;
            amp0_q_r <= 1'b0;
            amp1_q_r <= 1'b0;
        end else begin
            ext_q_r <= src_in.ext_pin;
            cmp_q_r <= src_in.cmp_out;
            amp0_q_r <= src_in.amp0_out;
            amp1_q_r <= src_in.amp1_out;
        end
    end

    assign ext_rise = src_in.ext_pin & ~ext_q_r;
    assign ext_fall = ~src_in.ext_pin & ext_q_r;
    assign cmp_rise = src_in.cmp_out & ~cmp_q_r;
    assign cmp_fall = ~src_in.cmp_out & cmp_q_r;

    // External edge type select, code 00 turns the pin off
    always_comb begin
        case (misc_r[7:6])
            `VIC_EXT_RISE: ext_evt = ext_rise;
            `VIC_EXT_FALL: ext_evt = ext_fall;
            `VIC_EXT_BOTH: ext_evt = ext_rise | ext_fall;
            default: ext_evt = 1'b0;
        endcase
    end

    // Comparator edge type; reserved code raises nothing
    always_comb begin
        case (rout_r[1:0])
            `VIC_CMP_FALL: cmp_evt = cmp_fall;
            `VIC_CMP_RISE: cmp_evt = cmp_rise;
            `VIC_CMP_BOTH: cmp_evt = cmp_rise | cmp_fall;
            default: cmp_evt = 1'b0;
        endcase
    end

    // Sub-source events: comparator, amp0 fall, amp1 fall
    assign sub_ev = {~src_in.amp1_out & amp1_q_r, ~src_in.amp0_out & amp0_q_r, cmp_evt};
    // Multi-source request follows any enabled sub-source event
    assign ev = {|(sub_ev & mfic_r[2:0]), src_in.time_base, src_in.timer1_ovf,
                 src_in.timer0_ovf, ext_evt};

    // Priority pick: lowest index wins
    assign live = req_r & en;
    always_comb begin
        win = 5'b0_0000;
        for (int i = 4; i >= 0; i--) begin
            if (live[i]) begin
                win = 5'b0_0000;
                win[i] = 1'b1;
            end
        end
    end

    // Vector table
    always_comb begin
        case (win)
            5'b0_0001: win_vec = `VIC_VEC_EXT;
            5'b0_0010: win_vec = `VIC_VEC_T0;
            5'b0_0100: win_vec = `VIC_VEC_T1;
            5'b0_1000: win_vec = `VIC_VEC_TB;
            5'b1_0000: win_vec = `VIC_VEC_MF;
            default: win_vec = 8'h00;
        endcase
    end

    // Pending needs global enable, an enabled flag and room on the stack
    assign irq_pending_out = gie & (|live) & ~stack_full_in;
    // Sampling only at the second-phase pulse keeps decisions aligned to cycles
    assign capture = (state_r == VIC_IDLE) & second_clock_phase_in & irq_pending_out;
    assign svc = capture ? win : 5'b0_0000;

    // Avalon slave: one wait cycle, then answer
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
    assign wr_go = avs_write_in & ack_r & avs_byteenable_in[0];
    assign wr_a = wr_go & (avs_address_in == `VIC_OFF_CTLA);
    assign wr_b = wr_go & (avs_address_in == `VIC_OFF_CTLB);
    assign wr_m = wr_go & (avs_address_in == `VIC_OFF_MFIC);

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (avs_address_in)
            `VIC_OFF_CTLA: rdata_nxt[7:0] = {1'b0, req_r[2:0], ctla_r} & `VIC_MASK_CTLA;
            `VIC_OFF_CTLB: rdata_nxt[7:0] = {1'b0, req_r[4:3], 2'b00, ctlb_r} & `VIC_MASK_CTLB;
            `VIC_OFF_MFIC: rdata_nxt[7:0] = {1'b0, sub_r, 1'b0, mfic_r} & `VIC_MASK_MFIC;
            `VIC_OFF_MISC: rdata_nxt[7:0] = misc_r & `VIC_MASK_MISC;
            `VIC_OFF_ROUT: rdata_nxt[7:0] = rout_r & `VIC_MASK_ROUT;
            `VIC_OFF_STAT: rdata_nxt[15:0] = {vec_r, 3'b000, state_r, irq_pending_out};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Bus handshake and read data capture
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ack_r <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
            if (avs_read_in & ~ack_r) begin
                avs_readdata_out <= rdata_nxt;
            end
        end
    end

    // Enables, global enable and config bits
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctla_r <= '0;
            ctlb_r <= '0;
            mfic_r <= '0;
            misc_r <= `VIC_RST_REG;
            rout_r <= `VIC_RST_REG;
        end else begin
            if (wr_a) begin
                ctla_r[3:0] <= avs_writedata_in[3:0];
            end
            // Auto clear beats a same-cycle software write, no nesting by accident
            if (capture) begin
                ctla_r[0] <= 1'b0;
            end
            if (wr_b) begin
                ctlb_r[2:0] <= avs_writedata_in[2:0];
            end
            if (wr_m) begin
                mfic_r[2:0] <= avs_writedata_in[2:0];
            end
            if (wr_go & (avs_address_in == `VIC_OFF_MISC)) begin
                misc_r <= avs_writedata_in[7:0] & `VIC_MASK_MISC;
            end
            if (wr_go & (avs_address_in == `VIC_OFF_ROUT)) begin
                rout_r <= avs_writedata_in[7:0] & `VIC_MASK_ROUT;
            end
        end
    end

    assign req_wr = {wr_b, wr_b, wr_a, wr_a, wr_a};
    assign req_wd = {avs_writedata_in[6:5], avs_writedata_in[6:4]};
    assign sub_wd = avs_writedata_in[6:4];

    // Sticky flags: event beats clear, software write or service clear otherwise
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            req_r <= 5'b0_0000;
            sub_r <= 3'b000;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (ev[i]) begin
                    req_r[i] <= 1'b1;
                end else if (req_wr[i]) begin
                    req_r[i] <= req_wd[i];
                end else if (svc[i]) begin
                    req_r[i] <= 1'b0;
                end
            end
            for (int j = 0; j < 3; j++) begin
                if (sub_ev[j]) begin
                    sub_r[j] <= 1'b1;
                end else if (wr_m) begin
                    sub_r[j] <= sub_wd[j];
                end
            end
        end
    end

    // Sequencer: sample, wait latency, push, jump
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            VIC_IDLE: begin
                if (capture) begin
                    state_nxt = VIC_WAIT;
                    cnt_nxt = sleep_wake_in ? `VIC_LAT_WAKE : `VIC_LAT_RUN;
                end
            end
            VIC_WAIT: begin
                if (second_clock_phase_in) begin
                    if (cnt_r == 2'd1) begin
                        state_nxt = VIC_PUSH;
                    end
                    cnt_nxt = cnt_r - 2'd1;
                end
            end
            VIC_PUSH: state_nxt = VIC_JUMP;
            VIC_JUMP: state_nxt = VIC_IDLE;
            default: state_nxt = VIC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r <= VIC_IDLE;
            cnt_r <= 2'd0;
            vec_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (capture) begin
                vec_r <= win_vec;
            end
        end
    end

    // CPU strobes from flops; push carries return address, load the vector
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cpu_ctl_out <= '0;
        end else begin
            cpu_ctl_out.push <= (state_nxt == VIC_PUSH);
            cpu_ctl_out.load <= (state_nxt == VIC_JUMP);
            cpu_ctl_out.pop <= return_from_irq_instr_in;
            if (state_nxt == VIC_PUSH) begin
                cpu_ctl_out.addr <= pc_next_in;
            end else if (state_nxt == VIC_JUMP) begin
                cpu_ctl_out.addr <= {{(`VIC_PC_W-8){1'b0}}, vec_r};
            end
        end
    end
    assign irq_vector_out = vec_r;

    // Analog routing and pin controls, registered
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            timer0_event_out <= 1'b0;
            amp0_ref_pin_join_out <= 1'b0;
            amp1_ref_pin_join_out <= 1'b0;
            cmp_ref_pin_join_out <= 1'b0;
            ext_pin_pullup_out <= 1'b0;
        end else begin
            timer0_event_out <= rout_r[3] ? src_in.cmp_out : timer0_ext_input_pin_in;
            amp0_ref_pin_join_out <= rout_r[7] & (amp0_noninv_sel_in == `VIC_SEL_INTREF);
            amp1_ref_pin_join_out <= rout_r[6] & (amp1_noninv_sel_in == `VIC_SEL_INTREF);
            cmp_ref_pin_join_out <= rout_r[5] & (cmp_noninv_sel_in == `VIC_SEL_INTREF);
            // Pull-up follows its own enable even when the pin is the irq input
            ext_pin_pullup_out <= ext_pullup_en_in;
        end
    end

    // Helper: second-phase pulses seen since capture
    logic [1:0] lat_r;
    logic [1:0] t2_seen_r;
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lat_r <= 2'd0;
            t2_seen_r <= 2'd0;
        end else if (capture) begin
            lat_r <= cnt_nxt;
            t2_seen_r <= 2'd0;
        end else if ((state_r == VIC_WAIT) && second_clock_phase_in) begin
            t2_seen_r <= t2_seen_r + 2'd1;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_push;
        cpu_ctl_out.push && !cpu_ctl_out.load;
    endsequence
    sequence s_load;
        cpu_ctl_out.load && !cpu_ctl_out.push && cpu_ctl_out.addr[7:0] == vec_r;
    endsequence

    chk_gie_blocks: assert property (!gie |-> !capture)
        else $error("vector taken with global enable clear");
    chk_gie_autoclr: assert property (capture |=> !gie)
        else $error("global enable not cleared on service");
    chk_stack_full: assert property (stack_full_in |-> !capture)
        else $error("acknowledge while stack full");
    chk_push_load: assert property (s_push |=> s_load ##1 !cpu_ctl_out.load)
        else $error("push not followed by vector load");
    chk_jump_latency: assert property (cpu_ctl_out.push |-> t2_seen_r == lat_r)
        else $error("vector jump latency wrong");
    chk_ext_first: assert property (capture && live[0] |=> vec_r == `VIC_VEC_EXT)
        else $error("external irq lost priority");
    chk_ext_clear: assert property (capture && win[0] && !ev[0] |=> !req_r[0])
        else $error("external flag not cleared on service");
    chk_flag_set: assert property (ev[1] |=> req_r[1])
        else $error("timer 0 flag not set");
    chk_flag_sticky: assert property ($fell(req_r[3]) |-> $past(wr_b) || $past(svc[3]))
        else $error("time base flag dropped");
    chk_pop_ret: assert property (return_from_irq_instr_in |=> cpu_ctl_out.pop)
        else $error("no pop on return");
    chk_tmr_route: assert property (rout_r[3] |=> timer0_event_out == $past(src_in.cmp_out))
        else $error("timer 0 source not comparator");
endmodule

// ---- vic_cpu_model.sv ----
`timescale 1ns/1ps
`include "vic_cfg.svh"
// Behavioural CPU core with phase pulses, fetch PC and a return stack
module vic_cpu_model #(
    parameter int DEPTH = 4,
    parameter int PHASE = 4
) (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input vic_pkg::vic_cpu_t cpu_ctl_in,
    input wire logic call_cmd_in,
    input wire logic return_from_irq_instr_cmd_in,
    output logic second_clock_phase_out,
    output logic [`VIC_PC_W-1:0] pc_next_out,
    output logic stack_full_out,
    output logic return_from_irq_instr_out,
    output logic [`VIC_PC_W-1:0] ret_addr_out
);
    import vic_pkg::*;
    logic [`VIC_PC_W-1:0] stk_r [DEPTH];
    int depth_r;
    int ph_r;
    // One phase pulse per instruction cycle
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ph_r <= 0;
            second_clock_phase_out <= 1'b0;
        end else begin
            ph_r <= (ph_r == PHASE - 1) ? 0 : ph_r + 1;
            second_clock_phase_out <= (ph_r == PHASE - 1);
        end
    end
    // Stack and PC; pop first so a return never loses its address
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pc_next_out <= 12'h100;
            depth_r <= 0;
            return_from_irq_instr_out <= 1'b0;
            ret_addr_out <= '0;
        end else begin
            return_from_irq_instr_out <= return_from_irq_instr_cmd_in;
            if (cpu_ctl_in.pop && depth_r > 0) begin
                depth_r <= depth_r - 1;
                pc_next_out <= stk_r[depth_r-1];
                ret_addr_out <= stk_r[depth_r-1];
            end else if ((cpu_ctl_in.push || call_cmd_in) && depth_r < DEPTH) begin
                stk_r[depth_r] <= cpu_ctl_in.push ? cpu_ctl_in.addr : pc_next_out;
                depth_r <= depth_r + 1;
            end else if (cpu_ctl_in.load) begin
                pc_next_out <= cpu_ctl_in.addr;
            end else if (second_clock_phase_out) begin
                pc_next_out <= pc_next_out + 1'b1;
            end
        end
    end
    // Full stack reported as a level
    assign stack_full_out = (depth_r == DEPTH);
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "vic_cfg.svh"
module testbench;
    import vic_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] addr = '0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    vic_src_t src = '0;
    logic t0pin = 1'b0;
    logic [2:0] sel0 = '0;
    logic [2:0] sel1 = '0;
    logic [2:0] selc = '0;
    logic pu_en = 1'b0;
    logic wake = 1'b0;
    logic call_cmd = 1'b0;
    logic return_from_irq_instr_cmd = 1'b0;
    logic t2, full, return_from_irq_instr, pending, t0_evt, j0, j1, jc, pu_out;
    logic [11:0] pc_next, ret_addr, pc_last, saved_pc;
    logic [7:0] vec_out;
    vic_cpu_t cpu_ctl;
    logic [31:0] q;
    logic busy = 1'b0;
    int t2_cnt, lat_seen, pushes, loads, pops;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] vecs [5] = '{`VIC_VEC_EXT, `VIC_VEC_T0, `VIC_VEC_T1, `VIC_VEC_TB, `VIC_VEC_MF};
    logic [4:0] offs [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
    always #2 clk = ~clk;
    vic_ctrl DUT (.sys_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr),
        .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .src_in(src), .timer0_ext_input_pin_in(t0pin), .amp0_noninv_sel_in(sel0),
        .amp1_noninv_sel_in(sel1), .cmp_noninv_sel_in(selc), .ext_pullup_en_in(pu_en),
        .second_clock_phase_in(t2), .sleep_wake_in(wake), .stack_full_in(full),
        .return_from_irq_instr_in(return_from_irq_instr), .pc_next_in(pc_next), .irq_pending_out(pending),
        .irq_vector_out(vec_out), .cpu_ctl_out(cpu_ctl), .timer0_event_out(t0_evt),
        .amp0_ref_pin_join_out(j0), .amp1_ref_pin_join_out(j1),
        .cmp_ref_pin_join_out(jc), .ext_pin_pullup_out(pu_out));
    vic_cpu_model CPU (.sys_clk_in(clk), .rst_b_in(rst_b), .cpu_ctl_in(cpu_ctl),
        .call_cmd_in(call_cmd), .return_from_irq_instr_cmd_in(return_from_irq_instr_cmd), .second_clock_phase_out(t2),
        .pc_next_out(pc_next), .stack_full_out(full), .return_from_irq_instr_out(return_from_irq_instr),
        .ret_addr_out(ret_addr));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Avalon cycle: hold everything until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= {24'h0, d};
        wr_en <= w;
        rd_en <= !w;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] m,
        input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(what, {24'h0, e}, q & {24'h0, m});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Level sources toggle; timer sources get a one-cycle pulse
    task automatic tog(input vic_src_t v, input logic p);
        @(posedge clk);
        src <= src ^ v;
        if (p) begin
            @(posedge clk);
            src <= src ^ v;
        end
        cyc(3);
    endtask
    task automatic gie_on();
        bus(1'b0, `VIC_OFF_CTLA, 8'h00);
        bus(1'b1, `VIC_OFF_CTLA, q[7:0] | 8'h01);
    endtask
    task automatic wait_load(input logic [7:0] v, input int lat);
        int l0;
        l0 = loads;
        for (int k = 0; k < 200 && loads == l0; k++) @(negedge clk);
        check("vector", 32'(v), cpu_ctl.addr);
        check("vector port", 32'(v), 32'(vec_out));
        check("latency", lat, lat_seen);
    endtask
    task automatic do_return_from_irq_instr();
        int p0;
        p0 = pops;
        @(posedge clk);
        return_from_irq_instr_cmd <= 1'b1;
        @(posedge clk);
        return_from_irq_instr_cmd <= 1'b0;
        cyc(3);
        check("pop", p0 + 1, pops);
        check("return addr", 32'(saved_pc), 32'(ret_addr));
    endtask
    task automatic end_test(input string name);
        $display("Test %s done, mismatches so far %0d", name, num_errors);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Vector sequence monitor, sampled mid-cycle where outputs are settled
    always @(negedge clk) begin
        if (cpu_ctl.push) begin
            check("push addr", 32'(pc_last), 32'(cpu_ctl.addr));
            lat_seen = t2_cnt;
            saved_pc = cpu_ctl.addr;
            pushes++;
        end
        if (cpu_ctl.load) begin
            loads++;
            busy = 1'b0;
        end
        if (cpu_ctl.pop) pops++;
        if (busy && t2) t2_cnt++;
        if (!busy && pending === 1'b1 && t2) begin
            busy = 1'b1;
            t2_cnt = 0;
        end
        pc_last = pc_next;
    end
    // Watchdog sized well above the scenario length
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    initial begin
        int p0;
        logic [7:0] rst_exp;
        cyc(8);
        rst_b <= 1'b1;
        foreach (offs[i]) begin
            rst_exp = (offs[i] == `VIC_OFF_STAT) ? {3'b000, VIC_IDLE, 1'b0} : `VIC_RST_REG;
            rd_chk("reset value", offs[i], 8'hFF, rst_exp);
        end
        end_test("reset");
        be <= 4'h0;
        bus(1'b1, `VIC_OFF_ROUT, 8'hFF);
        be <= 4'hF;
        rd_chk("byte enable", `VIC_OFF_ROUT, 8'hFF, 8'h00);
        bus(1'b1, `VIC_OFF_ROUT, 8'hFF);
        rd_chk("routing mask", `VIC_OFF_ROUT, 8'hFF, `VIC_MASK_ROUT);
        check("joins", 3'b111, {j0, j1, jc});
        sel0 <= 3'b001;
        tog(7'b0000100, 1'b0);
        check("join sel", 3'b011, {j0, j1, jc});
        check("t0 from cmp", 1'b1, t0_evt);
        bus(1'b1, `VIC_OFF_ROUT, 8'h00);
        tog(7'b0000100, 1'b0);
        t0pin <= 1'b1;
        cyc(3);
        check("t0 from pin", 1'b1, t0_evt);
        end_test("routing");
        pu_en <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, `VIC_OFF_MISC, 8'(c << 6));
            bus(1'b1, `VIC_OFF_CTLA, 8'h00);
            tog(7'b0001000, 1'b0);
            rd_chk("ext rise", `VIC_OFF_CTLA, 8'h10, {3'b000, c[0], 4'h0});
            bus(1'b1, `VIC_OFF_CTLA, 8'h00);
            tog(7'b0001000, 1'b0);
            rd_chk("ext fall", `VIC_OFF_CTLA, 8'h10, {3'b000, c[1], 4'h0});
        end
        check("pull-up", 1'b1, pu_out);
        for (int c = 0; c < 3; c++) begin
            bus(1'b1, `VIC_OFF_ROUT, 8'(c));
            bus(1'b1, `VIC_OFF_MFIC, 8'h00);
            tog(7'b0000100, 1'b0);
            rd_chk("cmp rise", `VIC_OFF_MFIC, 8'h10, {3'b000, c != 0, 4'h0});
            bus(1'b1, `VIC_OFF_MFIC, 8'h00);
            tog(7'b0000100, 1'b0);
            rd_chk("cmp fall", `VIC_OFF_MFIC, 8'h10, {3'b000, c != 1, 4'h0});
        end
        bus(1'b1, `VIC_OFF_MFIC, 8'h00);
        tog(7'b0000010, 1'b0);
        rd_chk("amp rise", `VIC_OFF_MFIC, 8'h20, 8'h00);
        tog(7'b0000010, 1'b0);
        rd_chk("amp fall", `VIC_OFF_MFIC, 8'h20, 8'h20);
        tog(7'b0000001, 1'b0);
        tog(7'b0000001, 1'b0);
        rd_chk("amp1 fall", `VIC_OFF_MFIC, 8'h40, 8'h40);
        end_test("edges");
        bus(1'b1, `VIC_OFF_CTLA, 8'h0E);
        bus(1'b1, `VIC_OFF_CTLB, 8'h06);
        bus(1'b1, `VIC_OFF_MFIC, 8'h01);
        bus(1'b1, `VIC_OFF_MISC, 8'h40);
        bus(1'b1, `VIC_OFF_ROUT, 8'h01);
        tog(7'b1000000, 1'b1);
        tog(7'b0100000, 1'b1);
        tog(7'b0010000, 1'b1);
        tog(7'b0001000, 1'b0);
        tog(7'b0000100, 1'b0);
        p0 = pushes;
        cyc(20);
        check("masked pending", 1'b0, pending);
        check("masked push", p0, pushes);
        rd_chk("flags a", `VIC_OFF_CTLA, 8'hFF, 8'h7E);
        rd_chk("flags b", `VIC_OFF_CTLB, 8'hFF, 8'h66);
        end_test("masked");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            wake <= (i == 4);
            gie_on();
            wait_load(vecs[i], (i == 4) ? 3 : 2);
            rd_chk("gie cleared", `VIC_OFF_CTLA, 8'h01, 8'h00);
            if (i == 0) rd_chk("ext flag", `VIC_OFF_CTLA, 8'h10, 8'h00);
            do_return_from_irq_instr();
        end
        rd_chk("sub flag kept", `VIC_OFF_MFIC, 8'h10, 8'h10);
        rd_chk("multi cleared", `VIC_OFF_CTLB, 8'h40, 8'h00);
        end_test("priority");
        wake <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            call_cmd <= 1'b1;
            @(posedge clk);
            call_cmd <= 1'b0;
        end
        tog(7'b1000000, 1'b1);
        p0 = pushes;
        gie_on();
        cyc(20);
        check("full pending", 1'b0, pending);
        check("full push", p0, pushes);
        @(posedge clk);
        return_from_irq_instr_cmd <= 1'b1;
        @(posedge clk);
        return_from_irq_instr_cmd <= 1'b0;
        wait_load(`VIC_VEC_T0, 2);
        end_test("stack full");
        finish_test();
    end
endmodule
